// File: inc/wcw_defs.vh
/*
 * Constants of the windowed countdown watchdog: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 100 MHz CPU clock and a 32-bit APB register bus.
 */
// Notes on behaviour
// - The 7-bit count drops by one every 49,152 CPU clock cycles.
// - Armed, a count step from 40h to 3Fh pulls the reset pin low 500 ns.
// - The delay is set in 64 steps through the low six count bits.
// - After any reset the watchdog is disarmed and cannot cause a reset.
// - Once armed, software cannot disarm it; only a reset does.
// - Writing the arm bit set with the count top bit clear resets at once.
// - In halt mode the count is frozen and no watchdog reset occurs.
// - After an interrupt wake from halt, counting resumes after 4096 cycles.
// - A reset that ends halt mode leaves the watchdog in its reset state.
// - Control register: arm bit at bit 7, count at bits 6:0, reset 7Fh.
// - The arm bit is set only by software and cleared only by reset.
`ifndef WCW_DEFS_VH
`define WCW_DEFS_VH

`define WCW_CTRL_ADDR       12'h00C
`define WCW_STAT_ADDR       12'h010
`define WCW_MASK_ADDR       12'h014

`define WCW_ARM_BIT         7
`define WCW_TOP_BIT         6
`define WCW_CNT_MSB         6
`define WCW_CNT_RST         7'h7F
`define WCW_ARM_RST         1'b0
`define WCW_TRIP_CNT        7'h40

`define WCW_EV_TIMEOUT      0
`define WCW_EV_SOFT         1
`define WCW_EV_WIDTH        2
`define WCW_STAT_RST        2'h0
`define WCW_MASK_RST        2'h0
`define WCW_PIN_BIT         8

`define WCW_CLK_MHZ         100
`define WCW_TICK_CYCLES     49152
`define WCW_PULSE_NS        500
`define WCW_PULSE_CYC       8'h32
`define WCW_WAKE_CYC        4096
`define WCW_WAKE_LAST       13'h0FFF

`endif

// File: core/wcw_top.v
/*
 * Windowed countdown watchdog with APB register access, a sticky event
 * status register, an interrupt mask and an open-drain reset pin driver.
 * Assumes halt_in and wake_in come from CPU logic on clk_in, and that the
 * reset pin is an open-drain wire whose level comes back on reset_pin_in.
 */
`include "wcw_defs.vh"

module wcw_top #(
    parameter TICK_CYCLES = `WCW_TICK_CYCLES
) (
    input  wire        clk_in,
    input  wire        arst_n_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire        halt_in,
    input  wire        wake_in,
    input  wire        reset_pin_in,
    output reg         reset_pin_out,
    output reg         reset_pin_oe_n_out,
    output reg         irq_out
);

    localparam ST_RUN  = 2'h0;
    localparam ST_HALT = 2'h1;
    localparam ST_WAKE = 2'h2;

    reg [1:0]                 state_q;
    reg [1:0]                 state_d;
    reg [15:0]                div_q;
    reg [15:0]                div_d;
    reg [12:0]                wake_q;
    reg [12:0]                wake_d;
    reg [6:0]                 cnt_q;
    reg [6:0]                 cnt_d;
    reg                       arm_q;
    reg                       arm_d;
    reg [7:0]                 pulse_q;
    reg [7:0]                 pulse_d;
    reg                       oe_n_d;
    reg [`WCW_EV_WIDTH-1:0]   stat_q;
    reg [`WCW_EV_WIDTH-1:0]   mask_q;
    reg [`WCW_EV_WIDTH-1:0]   mask_d;
    reg                       irq_d;
    reg [31:0]                prdata_d;
    reg                       pready_d;
    reg                       pslverr_d;
    reg                       pin_s1_q;
    reg                       pin_s2_q;
    reg                       hit_ctl;
    reg                       hit_st;
    reg                       hit_msk;
    reg                       soft_rst;
    reg                       time_rst;

    // Bus decode and strobes
    wire setup   = psel_in & ~penable_in;
    wire access  = psel_in & penable_in & pready_out;
    wire wr      = access & pwrite_in;
    wire mapped  = hit_ctl | hit_st | hit_msk;
    wire wr_ctl  = wr & hit_ctl;
    wire running = state_q == ST_RUN;
    wire tick    = running & (div_q == TICK_CYCLES - 1);
    wire new_arm = arm_q | pwdata_in[`WCW_ARM_BIT];

    // Event strobes
    reg [`WCW_EV_WIDTH-1:0] ev;
    always @* begin
        ev = {`WCW_EV_WIDTH{1'b0}};
        ev[`WCW_EV_TIMEOUT] = time_rst;
        ev[`WCW_EV_SOFT] = soft_rst & ~halt_in;
    end

    // Register address decode
    always @* begin
        hit_ctl = 1'b0;
        hit_st  = 1'b0;
        hit_msk = 1'b0;
        case (paddr_in)
            `WCW_CTRL_ADDR: begin
                hit_ctl = 1'b1;
            end
            `WCW_STAT_ADDR: begin
                hit_st = 1'b1;
            end
            `WCW_MASK_ADDR: begin
                hit_msk = 1'b1;
            end
            default: begin
                hit_ctl = 1'b0;
            end
        endcase
    end

    // Trip detection; a control write wins over the tick
    always @* begin
        soft_rst = 1'b0;
        time_rst = 1'b0;
        if (wr_ctl) begin
            soft_rst = new_arm & ~pwdata_in[`WCW_TOP_BIT];
        end else if (tick & arm_q) begin
            time_rst = cnt_q == `WCW_TRIP_CNT;
        end
    end

    // Halt and wake sequencing
    always @* begin
        state_d = state_q;
        wake_d  = wake_q;
        case (state_q)
            ST_RUN: begin
                if (halt_in) begin
                    state_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (wake_in) begin
                    state_d = ST_WAKE;
                    wake_d  = 13'h0000;
                end
            end
            ST_WAKE: begin
                if (wake_q == `WCW_WAKE_LAST) begin
                    state_d = ST_RUN;
                end else begin
                    wake_d = wake_q + 13'h0001;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Sequencer flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_RUN;
            wake_q  <= 13'h0000;
        end else begin
            state_q <= state_d;
            wake_q  <= wake_d;
        end
    end

    // Cycle divider, counting only in the run state and held in halt and wake
    always @* begin
        div_d = div_q;
        if (tick) begin
            div_d = 16'h0000;
        end else if (running) begin
            div_d = div_q + 16'h0001;
        end
    end

    // Divider flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_d;
        end
    end

    // Control register: arm bit and count
    always @* begin
        arm_d = arm_q;
        cnt_d = cnt_q;
        if (wr_ctl) begin
            arm_d = new_arm;
            cnt_d = pwdata_in[`WCW_CNT_MSB:0];
        end else if (tick) begin
            cnt_d = cnt_q - 7'h01;
        end
    end

    // Control register flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            arm_q <= `WCW_ARM_RST;
            cnt_q <= `WCW_CNT_RST;
        end else begin
            arm_q <= arm_d;
            cnt_q <= cnt_d;
        end
    end

    // Reset pin pulse
    always @* begin
        pulse_d = pulse_q;
        oe_n_d  = 1'b1;
        if (time_rst | ev[`WCW_EV_SOFT]) begin
            pulse_d = `WCW_PULSE_CYC;
            oe_n_d  = 1'b0;
        end else if (pulse_q != 8'h00) begin
            pulse_d = pulse_q - 8'h01;
            oe_n_d  = (pulse_q == 8'h01);
        end
    end

    // Reset pin flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pulse_q            <= 8'h00;
            reset_pin_out      <= 1'b0;
            reset_pin_oe_n_out <= 1'b1;
        end else begin
            pulse_q            <= pulse_d;
            reset_pin_out      <= 1'b0;
            reset_pin_oe_n_out <= oe_n_d;
        end
    end

    // Reset pin level synchroniser
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            pin_s1_q <= reset_pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Sticky status, mask and interrupt
    genvar gi;
    generate
        for (gi = 0; gi < `WCW_EV_WIDTH; gi = gi + 1) begin : g_ev
            wire set_w = ev[gi];
            wire clr_w = wr & hit_st & pwdata_in[gi];
            always @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    stat_q[gi] <= 1'b0;
                end else if (set_w) begin
                    stat_q[gi] <= 1'b1;
                end else if (clr_w) begin
                    stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @* begin
        mask_d = mask_q;
        if (wr & hit_msk) begin
            mask_d = pwdata_in[`WCW_EV_WIDTH-1:0];
        end
        irq_d = |(stat_q & mask_q);
    end

    // Mask and interrupt flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_q  <= `WCW_MASK_RST;
            irq_out <= 1'b0;
        end else begin
            mask_q  <= mask_d;
            irq_out <= irq_d;
        end
    end

    // APB slave: one wait-free access phase after each setup
    always @* begin
        pready_d  = setup;
        pslverr_d = setup & ~mapped;
        prdata_d  = prdata_out;
        if (setup & ~pwrite_in) begin
            if (hit_ctl) begin
                prdata_d = {24'h000000, arm_q, cnt_q};
            end else if (hit_st) begin
                prdata_d = {23'h000000, pin_s2_q, 6'h00, stat_q};
            end else if (hit_msk) begin
                prdata_d = {30'h00000000, mask_q};
            end else begin
                prdata_d = 32'h00000000;
            end
        end else if (access) begin
            prdata_d = 32'h00000000;
        end
    end

    // Bus response flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
        end else begin
            pready_out  <= pready_d;
            pslverr_out <= pslverr_d;
            prdata_out  <= prdata_d;
        end
    end

endmodule // wcw_top

// File: tb/wcw_top_properties.sv
/*
 * Port checker for the countdown watchdog, bound to its top module.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
`include "wcw_defs.vh"
module wcw_properties #(parameter TICK_CYCLES = `WCW_TICK_CYCLES) (
    input wire        clk_in,
    input wire        arst_n_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        halt_in,
    input wire        reset_pin_out,
    input wire        reset_pin_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    logic [7:0] low_q;
    wire        map_w = paddr_in == `WCW_CTRL_ADDR ||
        paddr_in == `WCW_STAT_ADDR || paddr_in == `WCW_MASK_ADDR;
    // Length of the current low pulse on the reset pin
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) low_q <= 8'h00;
        else low_q <= reset_pin_oe_n_out ? 8'h00 : low_q + 8'h01;
    end
    ready_after_setup_a: assert property (psel_in && !penable_in |=>
        pready_out) else $error("no ready after setup");
    ready_in_access_a: assert property (pready_out |-> psel_in &&
        penable_in) else $error("ready outside access");
    error_decode_a: assert property (pready_out |-> pslverr_out == !map_w)
        else $error("wrong error response");
    unmapped_zero_a: assert property (pready_out && !map_w |->
        prdata_out == 32'h0) else $error("unmapped read not zero");
    idle_rdata_a: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside access");
    pulse_width_a: assert property ($rose(reset_pin_oe_n_out) |->
        low_q == 8'h32) else $error("reset pulse length wrong");
    halt_quiet_a: assert property (halt_in && $past(halt_in) &&
        reset_pin_oe_n_out |=> reset_pin_oe_n_out)
        else $error("reset during halt");
    soft_reset_a: assert property (
        psel_in && penable_in && pready_out &&
        pwrite_in && paddr_in == `WCW_CTRL_ADDR && pwdata_in[7] &&
        !pwdata_in[6] && !halt_in |=> !reset_pin_oe_n_out)
        else $error("no soft reset");
    pin_low_a: assert property (!reset_pin_oe_n_out |-> !reset_pin_out)
        else $error("pin driven high");
endmodule // wcw_properties
bind wcw_top wcw_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .halt_in(halt_in),
    .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n_out(reset_pin_oe_n_out));

// File: tb/wcw_top_test.sv
/*
 * Self-checking bench for the countdown watchdog over APB.
 * Assumes the reset wire has a pull-up and a short tick of 16 cycles.
 */
`include "wcw_defs.vh"
module wcw_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0;
    logic pwrite_in = 0, halt_in = 0, wake_in = 0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, reset_pin_out, reset_pin_oe_n_out, irq_out;
    wire reset_pin_in = reset_pin_oe_n_out ? 1'b1 : reset_pin_out;
    int num_errors = 0, checked = 0, t, n;
    int steps[3];
    logic [32:0] notes[$];
    always #5 clk_in = ~clk_in;
    wcw_top #(.TICK_CYCLES(16)) dut_u (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .halt_in(halt_in), .wake_in(wake_in),
        .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n_out(reset_pin_oe_n_out), .irq_out(irq_out));
    task chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Monitor: each answer is compared with the oldest note
    always @(posedge clk_in) begin
        if (pready_out === 1'b1 && notes.size() > 0)
            chk({pslverr_out, pwrite_in ? 32'h0 : prdata_out},
                notes.pop_front());
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             input logic [32:0] e);
        notes.push_back(e);
        psel_in <= 1'b1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        psel_in <= 1'b0; penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task low_wait;
        t = 0;
        while (reset_pin_oe_n_out !== 1'b0 && t < 6000) begin
            @(posedge clk_in);
            t++;
        end
    endtask
    initial begin
        repeat (30000) @(posedge clk_in);
        num_errors++;
        end_of_test;
    end
    initial begin
        n = $urandom(94429);
        steps = '{0, 63, $urandom % 64};
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        apb(0, `WCW_CTRL_ADDR, 0, 33'h7F);
        apb(0, `WCW_STAT_ADDR, 0, 33'h100);
        apb(1, 12'h100 | ($urandom & 12'h0F0), $urandom, {1'b1, 32'h0});
        apb(0, 12'h008, 0, {1'b1, 32'h0});
        wr(`WCW_CTRL_ADDR, 32'h00);
        repeat (40) @(posedge clk_in);
        chk(reset_pin_oe_n_out, 1);
        $display("test registers done");
        foreach (steps[i]) begin
            wr(`WCW_CTRL_ADDR, 32'hC0 | steps[i]);
            low_wait;
            chk(t >= steps[i] * 16 - 2 && t <= steps[i] * 16 + 18,
                1);
            repeat (60) @(posedge clk_in);
        end
        $display("test timeout done");
        chk(irq_out, 0);
        apb(0, `WCW_STAT_ADDR, 0, 33'h101);
        wr(`WCW_MASK_ADDR, 32'h1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 1);
        wr(`WCW_STAT_ADDR, 32'h1);
        repeat (2) @(posedge clk_in);
        chk(irq_out, 0);
        wr(`WCW_CTRL_ADDR, 32'h00);
        repeat (2) @(posedge clk_in);
        chk(reset_pin_oe_n_out, 0);
        repeat (60) @(posedge clk_in);
        apb(0, `WCW_STAT_ADDR, 0, 33'h102);
        $display("test events done");
        wr(`WCW_CTRL_ADDR, 32'hC1);
        halt_in <= 1'b1;
        repeat (100) @(posedge clk_in);
        wr(`WCW_CTRL_ADDR, 32'h80);
        wr(`WCW_CTRL_ADDR, 32'hC1);
        chk(reset_pin_oe_n_out, 1);
        halt_in <= 1'b0;
        wake_in <= 1'b1;
        @(posedge clk_in);
        wake_in <= 1'b0;
        low_wait;
        chk(t >= 4090 && t <= 4140, 1);
        repeat (60) @(posedge clk_in);
        halt_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b0;
        halt_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        apb(0, `WCW_CTRL_ADDR, 0, 33'h7F);
        $display("test halt done");
        end_of_test;
    end
endmodule // wcw_top_test
